// [rtl/srfe_defines.vh]
`ifndef SRFE_DEFINES_VH
`define SRFE_DEFINES_VH

// Command byte field positions.
`define SRFE_CMD_ADDR_HI   7
`define SRFE_CMD_ADDR_LO   3
`define SRFE_CMD_ZERO_BIT  2
`define SRFE_CMD_DIR_BIT   1
`define SRFE_CMD_DONE_BIT  0

// Register number landmarks used by the address sequencer.
`define SRFE_LAST_FIFO_REG 5'h04
`define SRFE_FREEZE_REG    5'h14
`define SRFE_LAST_REG      5'h1F

// Widths and sizes.
`define SRFE_ADDR_W        5
`define SRFE_BYTE_W        8
`define SRFE_FIFO_DEPTH    8
`define SRFE_LAST_BIT      3'h7

// Reset values.
`define SRFE_RST_BYTE      8'h00
`define SRFE_RST_ADDR      5'h00
`define SRFE_RST_BITCNT    3'h0

`endif

// [rtl/srfe_sync.v]
`timescale 1ns/1ps
`default_nettype none

module srfe_sync #(
   parameter WIDTH = 3
) (
   input  wire             core_clk, // Core clock.
   input  wire             srst,     // Synchronous reset, active high.
   input  wire             ce,       // Clock enable.
   input  wire [WIDTH-1:0] async_in, // Inputs from outside the clock domain.
   input  wire [WIDTH-1:0] rst_val,  // Level that the stages hold in reset (constant at top).
   output reg  [WIDTH-1:0] sync_out  // Second stage, safe to read.
);

   reg [WIDTH-1:0] meta_q;

   ////////////////////////////////////////////////////////////////////////////
   // Two stages; only the second stage reads the first.
   always @(posedge core_clk) begin
      if (srst) begin
         meta_q   <= rst_val;
         sync_out <= rst_val;
      end else if (ce) begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

`default_nettype wire

// [rtl/srfe_fifo.v]
`timescale 1ns/1ps
`default_nettype none

module srfe_fifo #(
   parameter WIDTH = 13,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             core_clk,  // Core clock.
   input  wire             srst,      // Synchronous reset, active high.
   input  wire             ce,        // Clock enable.
   input  wire             in_valid,  // Write side offers a word.
   output wire             in_ready,  // Room for a word.
   input  wire [WIDTH-1:0] in_data,   // Word to store.
   output wire             out_valid, // A word is waiting.
   input  wire             out_ready, // Drain side takes the word.
   output wire [WIDTH-1:0] out_data   // Oldest word.
);

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_q;
   reg [AW-1:0]    rd_ptr_q;
   reg [AW:0]      count_q;
   wire            push;
   wire            pop;

   // Honest full and empty from the occupancy count.
   assign in_ready  = (count_q != DEPTH[AW:0]);
   assign out_valid = (count_q != {(AW+1){1'b0}});
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   ////////////////////////////////////////////////////////////////////////////
   // One storage entry per slot, written when the write pointer points at it.
   genvar i;
   generate
      for (i = 0; i < DEPTH; i = i + 1) begin : g_slot
         always @(posedge core_clk) begin
            if (srst) begin
               mem_q[i] <= {WIDTH{1'b0}};
            end else if (ce && push && (wr_ptr_q == i[AW-1:0])) begin
               mem_q[i] <= in_data;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Pointers wrap at the depth; the count tracks pushes minus pops.
   always @(posedge core_clk) begin
      if (srst) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q  <= {(AW+1){1'b0}};
      end else if (ce) begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            count_q <= count_q + 1'b1;
         end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// [rtl/srfe_top.v]
// What this block does
// - Every serial byte, in and out, travels most significant bit first.
// - Command bits seven to three select the starting register number.
// - Direction one writes data bytes to the register; zero reads it back.
// - In peripheral role, command done flag pulses the stall register flag set.
// - In host role the done flag is ignored, stall register untouched.
// - Full duplex: eight status bits go out while the command arrives.
// - Half duplex: no status during the command byte.
// - Accesses starting at registers zero to four keep the address fixed.
// - Registers five to nineteen advance the address after every data byte.
// - Register twenty holds the address for all further bytes.
// - Registers twenty-one to thirty advance; thirty-one holds.
// - Bits without function in the current role read as zero.
// - Role select switches to host operation and its register map.
// - Peripheral role offers 26 registers, host role 23, same protocol.
// - Select low frames a transfer; select high ignores clock, output floats.
// - Sample input on rising clock edge, change output on falling edge.
// - Command byte: number in seven to three, zero, direction, done flag.
`timescale 1ns/1ps
`default_nettype none
`include "srfe_defines.vh"

module srfe_top #(
   parameter AW    = `SRFE_ADDR_W,
   parameter DW    = `SRFE_BYTE_W,
   parameter DEPTH = `SRFE_FIFO_DEPTH
) (
   input  wire          core_clk,      // Core clock, 40 MHz.
   input  wire          srst,          // Synchronous reset, active high.
   input  wire          ce,            // Clock enable; low freezes all state.
   input  wire          sclk_pin,      // Serial clock from the master.
   input  wire          sel_n_pin,     // Active-low select from the master.
   input  wire          mosi_i,        // Serial data pin, input side.
   output wire          mosi_o,        // Serial data pin, output side (half duplex).
   output wire          mosi_oe,       // High while the block drives the data pin.
   output wire          miso_o,        // Serial data output (full duplex).
   output wire          miso_oe,       // High while the block drives the output pin.
   input  wire          fdx_en,        // High selects full-duplex serial mode.
   input  wire          host_mode,     // Role select: high is host operation.
   input  wire [DW-1:0] status_periph, // Status bits for peripheral role.
   input  wire [DW-1:0] status_host,   // Status bits for host role.
   output wire [AW-1:0] rd_addr,       // Register number being read.
   input  wire [DW-1:0] rd_data,       // Contents of that register.
   input  wire [DW-1:0] rd_mask,       // Ones mark bits that work in this role.
   output wire          rd_strobe,     // One-cycle pulse as a read byte is taken.
   output wire          wr_valid,      // A register write is offered.
   input  wire          wr_ready,      // Register file takes the write.
   output wire [AW-1:0] wr_addr,       // Register number of the write.
   output wire [DW-1:0] wr_data,       // Data of the write.
   output wire          ctl_done,      // One-cycle pulse: set the control done flag.
   output wire          overrun,       // Sticky: a write byte found the buffer full.
   output wire          busy           // High while a transfer is framed.
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_CMD  = 3'b010;
   localparam [2:0] ST_DATA = 3'b100;

   reg  [2:0]       state_q;
   reg  [2:0]       bitcnt_q;
   reg  [DW-1:0]    shin_q;
   reg  [DW-1:0]    tx_q;
   reg              out_bit_q;
   reg  [AW-1:0]    addr_q;
   reg              dir_q;
   reg              load_pend_q;
   reg              rd_strobe_q;
   reg              ctl_done_q;
   reg              overrun_q;
   reg              miso_oe_q;
   reg              mosi_oe_q;
   reg              busy_q;
   reg              sclk_d_q;
   reg              sel_n_d_q;
   reg              wr_valid_q;
   reg  [AW-1:0]    wr_addr_q;
   reg  [DW-1:0]    wr_data_q;
   wire [2:0]       pins_s;
   wire             sclk_s;
   wire             sel_n_s;
   wire             mosi_s;
   wire             sclk_rise;
   wire             sclk_fall;
   wire             sel_fall;
   wire             sel_rise;
   wire [DW-1:0]    byte_in;
   wire             byte_done;
   wire [DW-1:0]    status_sel;
   wire             push;
   wire             fifo_in_ready;
   wire             fifo_out_valid;
   wire             fifo_pop;
   wire [AW+DW-1:0] fifo_out_data;

   ////////////////////////////////////////////////////////////////////////////
   // Address advance after a data byte: fixed on the FIFO registers, on
   // register twenty and on the last register, otherwise one further.
   function [AW-1:0] next_addr;
      input [AW-1:0] a;
      begin
         if (a <= `SRFE_LAST_FIFO_REG) begin
            next_addr = a;
         end else if (a == `SRFE_FREEZE_REG) begin
            next_addr = a;
         end else if (a == `SRFE_LAST_REG) begin
            next_addr = a;
         end else begin
            next_addr = a + 1'b1;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pins from the master pass two flip-flops; select idles high.
   srfe_sync #(
      .WIDTH (3)
   ) u_sync (
      .core_clk (core_clk),
      .srst     (srst),
      .ce       (ce),
      .async_in ({sclk_pin, sel_n_pin, mosi_i}),
      .rst_val  (3'h2),
      .sync_out (pins_s)
   );

   assign sclk_s  = pins_s[2];
   assign sel_n_s = pins_s[1];
   assign mosi_s  = pins_s[0];

   // Edge detection on the synchronised copies only.
   always @(posedge core_clk) begin
      if (srst) begin
         sclk_d_q  <= 1'b0;
         sel_n_d_q <= 1'b1;
      end else if (ce) begin
         sclk_d_q  <= sclk_s;
         sel_n_d_q <= sel_n_s;
      end
   end

   // Clock edges count only while select is low.
   assign sclk_rise  = sclk_s & ~sclk_d_q & ~sel_n_s;
   assign sclk_fall  = ~sclk_s & sclk_d_q & ~sel_n_s;
   assign sel_fall   = ~sel_n_s & sel_n_d_q;
   assign sel_rise   = sel_n_s & ~sel_n_d_q;
   assign byte_in    = {shin_q[DW-2:0], mosi_s};
   assign byte_done  = sclk_rise & (bitcnt_q == `SRFE_LAST_BIT);
   assign status_sel = host_mode ? status_host : status_periph;
   assign push       = byte_done & (state_q == ST_DATA) & dir_q;

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencer: command byte, then data bytes until select rises.
   always @(posedge core_clk) begin
      if (srst) begin
         state_q     <= ST_IDLE;
         bitcnt_q    <= `SRFE_RST_BITCNT;
         shin_q      <= `SRFE_RST_BYTE;
         addr_q      <= `SRFE_RST_ADDR;
         dir_q       <= 1'b0;
         load_pend_q <= 1'b0;
         ctl_done_q  <= 1'b0;
         overrun_q   <= 1'b0;
      end else if (ce) begin
         ctl_done_q  <= 1'b0;
         load_pend_q <= 1'b0;
         if (push && !fifo_in_ready) begin
            overrun_q <= 1'b1;
         end
         case (state_q)
            ST_IDLE: begin
               if (sel_fall) begin
                  state_q  <= ST_CMD;
                  bitcnt_q <= `SRFE_RST_BITCNT;
                  addr_q   <= `SRFE_RST_ADDR;
               end
            end
            ST_CMD: begin
               if (sel_rise) begin
                  state_q <= ST_IDLE;
               end else if (sclk_rise) begin
                  shin_q   <= byte_in;
                  bitcnt_q <= bitcnt_q + 1'b1;
                  if (byte_done) begin
                     state_q <= ST_DATA;
                     addr_q  <= byte_in[`SRFE_CMD_ADDR_HI:`SRFE_CMD_ADDR_LO];
                     dir_q   <= byte_in[`SRFE_CMD_DIR_BIT];
                     // Peripheral role only: done flag sets the stall flag.
                     ctl_done_q  <= byte_in[`SRFE_CMD_DONE_BIT] & ~host_mode;
                     load_pend_q <= ~byte_in[`SRFE_CMD_DIR_BIT];
                  end
               end
            end
            ST_DATA: begin
               if (sel_rise) begin
                  state_q <= ST_IDLE;
               end else if (sclk_rise) begin
                  shin_q   <= byte_in;
                  bitcnt_q <= bitcnt_q + 1'b1;
                  if (byte_done) begin
                     addr_q      <= next_addr(addr_q);
                     load_pend_q <= ~dir_q;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outgoing byte: status at select fall (full duplex only), register data
   // one cycle after each byte boundary of a read, shifted on falling edges.
   always @(posedge core_clk) begin
      if (srst) begin
         tx_q        <= `SRFE_RST_BYTE;
         out_bit_q   <= 1'b0;
         rd_strobe_q <= 1'b0;
      end else if (ce) begin
         rd_strobe_q <= 1'b0;
         if (state_q == ST_IDLE) begin
            if (sel_fall && fdx_en) begin
               out_bit_q <= status_sel[DW-1];
               tx_q      <= {status_sel[DW-2:0], 1'b0};
            end else if (sel_fall) begin
               out_bit_q <= 1'b0;
               tx_q      <= `SRFE_RST_BYTE;
            end
         end else if (load_pend_q) begin
            // Bits with no function in this role read as zero.
            tx_q        <= rd_data & rd_mask;
            rd_strobe_q <= 1'b1;
         end else if (sclk_fall) begin
            out_bit_q <= tx_q[DW-1];
            tx_q      <= {tx_q[DW-2:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output enables follow the synchronised select; half duplex turns the
   // data pin round only for the data phase of a read.
   always @(posedge core_clk) begin
      if (srst) begin
         miso_oe_q <= 1'b0;
         mosi_oe_q <= 1'b0;
         busy_q    <= 1'b0;
      end else if (ce) begin
         miso_oe_q <= ~sel_n_s & fdx_en;
         mosi_oe_q <= ~sel_n_s & ~fdx_en & (state_q == ST_DATA) & ~dir_q;
         busy_q    <= (state_q != ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write bytes wait in the buffer until the register file accepts them.
   srfe_fifo #(
      .WIDTH (AW + DW),
      .DEPTH (DEPTH),
      .AW    (3)
   ) u_fifo (
      .core_clk  (core_clk),
      .srst      (srst),
      .ce        (ce),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   ({addr_q, byte_in}),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   assign fifo_pop = fifo_out_valid & (~wr_valid_q | wr_ready);

   // Registered write port; a stalled register file holds the word.
   always @(posedge core_clk) begin
      if (srst) begin
         wr_valid_q <= 1'b0;
         wr_addr_q  <= `SRFE_RST_ADDR;
         wr_data_q  <= `SRFE_RST_BYTE;
      end else if (ce) begin
         if (fifo_pop) begin
            wr_valid_q <= 1'b1;
            wr_addr_q  <= fifo_out_data[AW+DW-1:DW];
            wr_data_q  <= fifo_out_data[DW-1:0];
         end else if (wr_ready) begin
            wr_valid_q <= 1'b0;
         end
      end
   end

   // Every output comes straight from a flip-flop.
   assign mosi_o    = out_bit_q;
   assign miso_o    = out_bit_q;
   assign mosi_oe   = mosi_oe_q;
   assign miso_oe   = miso_oe_q;
   assign rd_addr   = addr_q;
   assign rd_strobe = rd_strobe_q;
   assign wr_valid  = wr_valid_q;
   assign wr_addr   = wr_addr_q;
   assign wr_data   = wr_data_q;
   assign ctl_done  = ctl_done_q;
   assign overrun   = overrun_q;
   assign busy      = busy_q;

endmodule

`default_nettype wire

// [verif/srfe_master.sv]
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Serial master model in mode 0, paced by the core clock's falling edges.
module srfe_master (
   input  wire logic core_clk, // Pacing clock.
   input  wire logic sdi,      // Data line as the master sees it.
   output var  logic sclk,     // Serial clock, low outside frames except while idle_clocks toggles it.
   output var  logic sel_n,    // Active-low select.
   output var  logic sdo       // Data driven by the master.
);
   // Link pins start idle.
   initial begin
      sclk = 1'b0;
      sel_n = 1'b1;
      sdo = 1'b0;
   end

   // One clock phase is four core cycles, a 200 ns link period.
   task automatic half();
      repeat (4) @(negedge core_clk);
   endtask

   // Opens a frame with the clock low.
   task automatic sel_lo();
      sel_n = 1'b0;
      half();
   endtask

   // Closes a frame after the clock has returned low.
   task automatic sel_hi();
      sclk = 1'b0;
      half();
      sel_n = 1'b1;
      half();
   endtask

   // Shifts n bits MSB first; a released line shows the inverse of its last value.
   task automatic xbyte(input logic [7:0] tx, input logic drive, input int n,
                        output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         sclk = 1'b0;
         sdo = drive ? tx[i] : ~sdo;
         half();
         rx[i] = sdi;
         sclk = 1'b1;
         half();
      end
   endtask

   // Toggles the clock with select high, which the block must ignore.
   task automatic idle_clocks();
      repeat (4) begin
         sclk = 1'b1;
         half();
         sclk = 1'b0;
         half();
      end
   endtask
endmodule

`default_nettype wire

// [verif/srfe_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "srfe_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Port checker for the serial front end.
module srfe_chk (
   input wire logic       core_clk,      // Core clock.
   input wire logic       srst,          // Synchronous reset.
   input wire logic       sel_n_pin,     // Select pin.
   input wire logic       fdx_en,        // Full duplex mode.
   input wire logic       host_mode,     // Host role.
   input wire logic [7:0] status_periph, // Peripheral status.
   input wire logic [4:0] rd_addr,       // Read address.
   input wire logic       rd_strobe,     // Read fetch pulse.
   input wire logic       wr_valid,      // Write offered.
   input wire logic       wr_ready,      // Write taken.
   input wire logic [4:0] wr_addr,       // Write address.
   input wire logic [7:0] wr_data,       // Write data.
   input wire logic       ctl_done,      // Done flag pulse.
   input wire logic       miso_o,        // Output data.
   input wire logic       miso_oe,       // Output enable.
   input wire logic       mosi_oe,       // Shared pin enable.
   input wire logic       busy           // Frame active.
);
   logic seen_q; // A read byte was fetched in this frame.

   // Marks the first fetch of a frame, so the command load is not mistaken for a step.
   always_ff @(posedge core_clk) begin
      if (srst || !busy) seen_q <= 1'b0;
      else if (rd_strobe) seen_q <= 1'b1;
   end

   // Addresses at which the sequencer stops.
   function automatic logic is_fixed(input logic [4:0] a);
      return a <= `SRFE_LAST_FIFO_REG || a == `SRFE_FREEZE_REG || a == `SRFE_LAST_REG;
   endfunction

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence sel_fall;
      $fell(sel_n_pin);
   endsequence
   sequence fdx_fall;
      sel_fall ##0 (fdx_en && !host_mode);
   endsequence

   chk_status_first_bit: assert property (
      fdx_fall |-> ##[1:5] (miso_oe && miso_o == status_periph[7]))
      else $error("status bit missing at frame start");
   chk_frame_busy: assert property (
      sel_fall |-> ##[1:5] busy) else $error("busy not raised by select");
   chk_oe_idle: assert property (
      sel_n_pin [*6] |-> !miso_oe && !mosi_oe) else $error("output driven while deselected");
   chk_half_quiet: assert property (
      !fdx_en && $past(!fdx_en) |-> !miso_oe) else $error("output enabled in half duplex");
   chk_host_no_done: assert property (
      host_mode && $past(host_mode) |-> !ctl_done) else $error("done pulse in host role");
   chk_done_pulse: assert property (
      ctl_done |=> !ctl_done) else $error("done pulse too long");
   chk_write_hold: assert property (
      wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
      else $error("write dropped before taken");
   chk_addr_freeze: assert property (
      seen_q && busy && is_fixed($past(rd_addr)) |-> $stable(rd_addr))
      else $error("address moved at a fixed register");
   chk_addr_step: assert property (
      seen_q && busy && !$stable(rd_addr) |-> rd_addr == $past(rd_addr) + 5'h01)
      else $error("address step not by one");
endmodule

bind srfe_top srfe_chk srfe_chk_i (
   .core_clk(core_clk), .srst(srst), .sel_n_pin(sel_n_pin), .fdx_en(fdx_en),
   .host_mode(host_mode), .status_periph(status_periph), .rd_addr(rd_addr),
   .rd_strobe(rd_strobe), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
   .wr_data(wr_data), .ctl_done(ctl_done), .miso_o(miso_o), .miso_oe(miso_oe),
   .mosi_oe(mosi_oe), .busy(busy));

`default_nettype wire

// [verif/srfe_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Bench for the serial front end with a register file model on its side.
module srfe_top_bench;
   localparam logic [7:0] ST_P = 8'hA5;
   localparam logic [7:0] ST_H = 8'h69;
   logic        core_clk;
   logic        srst = 1'b1;
   logic        fdx_en = 1'b1;
   logic        host_mode = 1'b0;
   logic        hold_wr = 1'b0;
   logic        wr_ready = 1'b0;
   logic        sclk, sel_n, sdo, sdi, data_pin;
   logic        mosi_o, mosi_oe, miso_o, miso_oe, rd_strobe, wr_valid, ctl_done;
   logic        overrun, busy;
   logic [4:0]  rd_addr, wr_addr;
   logic [7:0]  rd_data, rd_mask, wr_data;
   logic [7:0]  regs [0:31];
   logic [12:0] wq[$], eq[$];
   int          err_total = 0;
   int          samples_checked = 0;
   int          done_cnt = 0;
   int          strb_cnt = 0;
   logic [4:0]  starts [4] = '{5'h05, 5'h13, 5'h1E, 5'h02};

   // Shared data pin and the line the master reads; a floating output shows its inverse.
   assign data_pin = mosi_oe ? mosi_o : sdo;
   assign sdi = fdx_en ? (miso_oe ? miso_o : ~miso_o) : data_pin;
   assign rd_data = regs[rd_addr];
   assign rd_mask = host_mode ? 8'h3C : 8'hFF;

   srfe_top srfe_top_i (
      .core_clk(core_clk), .srst(srst), .ce(1'b1), .sclk_pin(sclk), .sel_n_pin(sel_n),
      .mosi_i(data_pin), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_o(miso_o),
      .miso_oe(miso_oe), .fdx_en(fdx_en), .host_mode(host_mode), .status_periph(ST_P),
      .status_host(ST_H), .rd_addr(rd_addr), .rd_data(rd_data), .rd_mask(rd_mask),
      .rd_strobe(rd_strobe), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
      .wr_data(wr_data), .ctl_done(ctl_done), .overrun(overrun), .busy(busy));
   srfe_master srfe_master_i (
      .core_clk(core_clk), .sdi(sdi), .sclk(sclk), .sel_n(sel_n), .sdo(sdo));

   // Clock at 40 MHz.
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Register write sink stalls every other cycle, or fully while held off.
   always @(negedge core_clk) wr_ready <= hold_wr ? 1'b0 : ~wr_ready;

   // Collects taken writes and done pulses.
   always @(posedge core_clk) begin
      if (wr_valid === 1'b1 && wr_ready) wq.push_back({wr_addr, wr_data});
      if (ctl_done === 1'b1) done_cnt++;
      if (rd_strobe === 1'b1) strb_cnt++;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [4:0] nxt(input logic [4:0] a);
      return (a <= 5'h04 || a == 5'h14 || a == 5'h1F) ? a : a + 5'h01;
   endfunction

   // Read frame of n data bytes starting at register a.
   // One fetch per data byte plus the prefetch after the last one.
   task automatic rd_burst(input logic [4:0] a, input int n);
      logic [7:0] rx;
      int         s0;
      s0 = strb_cnt;
      srfe_master_i.sel_lo();
      srfe_master_i.xbyte({a, 3'b000}, 1'b1, 8, rx);
      if (fdx_en) check(rx, host_mode ? ST_H : ST_P);
      for (int i = 0; i < n; i++) begin
         srfe_master_i.xbyte(8'h00, fdx_en, 8, rx);
         check(rx, regs[a] & rd_mask);
         a = nxt(a);
      end
      srfe_master_i.sel_hi();
      check(strb_cnt - s0, n + 1);
   endtask

   // Write frame of n bytes at register a with the done flag f.
   task automatic wr_burst(input logic [4:0] a, input logic f, input int n);
      logic [7:0] rx;
      srfe_master_i.sel_lo();
      srfe_master_i.xbyte({a, 2'b01, f}, 1'b1, 8, rx);
      for (int i = 0; i < n; i++) begin
         srfe_master_i.xbyte(8'h30 + i[7:0], 1'b1, 8, rx);
         eq.push_back({a, 8'h30 + i[7:0]});
         a = nxt(a);
      end
      srfe_master_i.sel_hi();
   endtask

   // Compares the first n taken writes with the expected ones.
   task automatic cmp_writes(input int n);
      repeat (60) @(negedge core_clk);
      check(wq.size() >= n, 1'b1);
      for (int i = 0; i < n && i < wq.size(); i++) check(wq[i], eq[i]);
      wq.delete();
      eq.delete();
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Main sequence.
   initial begin
      logic [7:0] rx;
      for (int i = 0; i < 32; i++) regs[i] = 8'h5A ^ (i[7:0] * 8'h11);
      repeat (16) @(negedge core_clk);
      srst = 1'b0;
      repeat (4) @(negedge core_clk);
      check({busy, miso_oe, mosi_oe, wr_valid, overrun, ctl_done, rd_strobe}, 16'h0000);
      foreach (starts[i]) rd_burst(starts[i], 3);
      host_mode = 1'b1;
      rd_burst(5'h06, 2);
      wr_burst(5'h09, 1'b1, 1);
      check(done_cnt, 16'h0000);
      host_mode = 1'b0;
      wr_burst(5'h14, 1'b1, 2);
      check(done_cnt, 16'h0001);
      cmp_writes(3);
      fdx_en = 1'b0;
      rd_burst(5'h07, 2);
      fdx_en = 1'b1;
      srfe_master_i.sel_lo();
      srfe_master_i.xbyte({5'h0A, 3'b010}, 1'b1, 8, rx);
      srfe_master_i.xbyte(8'hC3, 1'b1, 4, rx);
      srfe_master_i.sel_hi();
      srfe_master_i.idle_clocks();
      repeat (60) @(negedge core_clk);
      check(wq.size(), 16'h0000);
      rd_burst(5'h03, 1);
      hold_wr = 1'b1;
      wr_burst(5'h15, 1'b0, 10);
      check(overrun, 1'b1);
      hold_wr = 1'b0;
      cmp_writes(8);
      srst = 1'b1;
      repeat (16) @(negedge core_clk);
      srst = 1'b0;
      repeat (4) @(negedge core_clk);
      check({busy, overrun, wr_valid}, 16'h0000);
      final_report();
   end

   // Watchdog against a hung transfer.
   initial begin
      repeat (40000) @(posedge core_clk);
      err_total++;
      final_report();
   end
endmodule

`default_nettype wire
